/* File: rtl/flag_ops_map.svh */
// status flag bit positions, reset value and instruction word patterns
// assumes an 8-bit status register and 16-bit instruction words
`ifndef FLAG_OPS_MAP_SVH
`define FLAG_OPS_MAP_SVH
`define FLAG_C         3'd0
`define FLAG_Z         3'd1
`define FLAG_N         3'd2
`define FLAG_V         3'd3
`define FLAG_S         3'd4
`define FLAG_H         3'd5
`define FLAG_T         3'd6
`define FLAG_I         3'd7
`define STATUS_FLAG_REGISTER_RESET 8'h00
// flag set/clear: 1001 0100 Bsss 1000, B=1 clears
`define FLAGOP_MASK    16'hff0f
`define FLAGOP_MATCH   16'h9408
// bit load: 1111 100d dddd 0bbb
`define BITLOAD_MASK   16'hfe08
`define BITLOAD_MATCH  16'hf800
`define SLEEP_WORD     16'h9588
`define BREAK_WORD     16'h9598
`define WATCHDOG_RESTART_WORD 16'h95a8
`define OP_CYCLES      1
`endif

/* File: rtl/flag_ops_pkg.sv */
// types shared by the flag and system-op decoder
// assumes flag_ops_map.svh holds the numeric constants
package flag_ops_pkg;
    typedef enum logic [1:0] {
        SYS_NONE,
        SYS_SLEEP,
        SYS_WATCHDOG,
        SYS_BREAK
    } sys_op_t;

    typedef struct packed {
        logic       valid;
        logic       set_not_clear;
        logic [2:0] flag_sel;
    } flag_op_t;

    typedef struct packed {
        logic       valid;
        logic [4:0] reg_sel;
        logic [2:0] bit_sel;
    } bit_load_t;
endpackage : flag_ops_pkg

/* File: rtl/flag_op_decode.sv */
// combinational decode of the flag, bit-load and system instruction words
// assumes a 16-bit instruction word valid while insn_valid is high
`include "flag_ops_map.svh"
module flag_op_decode (
    input  wire logic                  insn_valid, // word present
    input  wire logic [15:0]           insn,       // instruction word
    output flag_ops_pkg::flag_op_t     flag_op,    // flag set/clear decode
    output flag_ops_pkg::bit_load_t    bit_load,   // bit-load decode
    output flag_ops_pkg::sys_op_t      sys_op      // system op decode
);
    always_comb begin
        flag_op.valid         = insn_valid && ((insn & `FLAGOP_MASK) == `FLAGOP_MATCH);
        flag_op.set_not_clear = ~insn[7];
        flag_op.flag_sel      = insn[6:4];
        bit_load.valid        = insn_valid && ((insn & `BITLOAD_MASK) == `BITLOAD_MATCH);
        bit_load.reg_sel      = insn[8:4];
        bit_load.bit_sel      = insn[2:0];
        sys_op                = flag_ops_pkg::SYS_NONE;
        if (insn_valid) begin
            unique case (insn)
                `SLEEP_WORD: sys_op = flag_ops_pkg::SYS_SLEEP;
                `WATCHDOG_RESTART_WORD: sys_op = flag_ops_pkg::SYS_WATCHDOG;
                `BREAK_WORD: sys_op = flag_ops_pkg::SYS_BREAK;
                default:     sys_op = flag_ops_pkg::SYS_NONE;
            endcase
        end
    end
endmodule : flag_op_decode

/* File: rtl/status_flag_and_system_ops.sv */
// status flag register with single-cycle flag, bit-load and system ops
// assumes the core presents one instruction word per clock; register file outside
// Function
// RULE1: bit load copies transfer flag into register bit
// RULE2: sign set/clear ops force only sign flag
// RULE3: overflow set/clear ops force only overflow flag
// RULE4: half carry set/clear ops force only half carry
// RULE5: sleep takes one cycle, signals sleep logic
// RULE6: watchdog restart takes one cycle, pulses watchdog
// RULE7: break goes only to debug, flags kept
// RULE8: carry, negative, zero, irq, transfer set/clear
`include "flag_ops_map.svh"
module status_flag_and_system_ops (
    input  wire logic        clk,            // core clock, 50 MHz
    input  wire logic        arst_n,         // async reset, active low
    input  wire logic        insn_valid,     // instruction word present
    input  wire logic [15:0] insn,           // instruction word
    input  wire logic [7:0]  rd_value,       // current destination register value
    input  wire logic        debug_enabled,  // on-chip debug system present
    output logic [7:0]       status_flags,   // status flag register
    output logic             wr_en,          // register file write strobe
    output logic [4:0]       wr_sel,         // register file write index
    output logic [7:0]       wr_data,        // register file write data
    output logic             sleep_req,      // one-cycle pulse to sleep logic
    output logic             watchdog_kick,  // one-cycle pulse to watchdog
    output logic             debug_break     // one-cycle pulse to debug system
);
    logic                    rst_meta_ff;
    logic                    nxt_rst_meta;
    logic                    rst_sync_ff;
    logic                    nxt_rst_sync;
    flag_ops_pkg::flag_op_t  flag_op;
    flag_ops_pkg::bit_load_t bit_load;
    flag_ops_pkg::sys_op_t   sys_op;
    logic                    flag_set_go;
    logic                    flag_clear_go;
    logic                    carry_set_op;
    logic                    carry_clear_op;
    logic                    zero_flag_set_op;
    logic                    zero_flag_clear_op;
    logic                    negative_set_op;
    logic                    negative_clear_op;
    logic                    overflow_set_op;
    logic                    overflow_clear_op;
    logic                    sign_flag_set_op;
    logic                    sign_flag_clear_op;
    logic                    half_carry_set_op;
    logic                    half_carry_clear_op;
    logic                    transfer_flag_set_op;
    logic                    transfer_flag_clear_op;
    logic                    global_irq_enable_op;
    logic                    global_irq_disable_op;
    logic [7:0]              flag_set_mask;
    logic [7:0]              flag_clear_mask;
    logic [7:0]              status_flag_register_ff;
    logic [7:0]              nxt_status_flag_register;
    logic                    transfer_bit_load;
    logic [7:0]              load_bits;
    logic                    wr_en_ff;
    logic                    nxt_wr_en;
    logic [4:0]              wr_sel_ff;
    logic [4:0]              nxt_wr_sel;
    logic [7:0]              wr_data_ff;
    logic [7:0]              nxt_wr_data;
    logic                    sleep_op;
    logic                    watchdog_restart_op;
    logic                    break_op;
    logic                    sleep_ff;
    logic                    nxt_sleep;
    logic                    wdog_ff;
    logic                    nxt_wdog;
    logic                    brk_ff;
    logic                    nxt_brk;

    // reset drops at once but leaves on the clock, so no flop sees a runt release
    always_comb begin
        nxt_rst_meta = 1'b1;
        nxt_rst_sync = rst_meta_ff;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_meta_ff <= 1'b0;
            rst_sync_ff <= 1'b0;
        end else begin
            rst_meta_ff <= nxt_rst_meta;
            rst_sync_ff <= nxt_rst_sync;
        end
    end

    flag_op_decode u_decode (
        .insn_valid (insn_valid),
        .insn       (insn),
        .flag_op    (flag_op),
        .bit_load   (bit_load),
        .sys_op     (sys_op)
    );

    // one named strobe per flag instruction
    always_comb begin
        flag_set_go            = flag_op.valid && flag_op.set_not_clear;
        flag_clear_go          = flag_op.valid && !flag_op.set_not_clear;
        carry_set_op           = flag_set_go && (flag_op.flag_sel == `FLAG_C); // RULE8
        carry_clear_op         = flag_clear_go && (flag_op.flag_sel == `FLAG_C); // RULE8
        zero_flag_set_op       = flag_set_go && (flag_op.flag_sel == `FLAG_Z); // RULE8
        zero_flag_clear_op     = flag_clear_go && (flag_op.flag_sel == `FLAG_Z); // RULE8
        negative_set_op        = flag_set_go && (flag_op.flag_sel == `FLAG_N); // RULE8
        negative_clear_op      = flag_clear_go && (flag_op.flag_sel == `FLAG_N); // RULE8
        overflow_set_op        = flag_set_go && (flag_op.flag_sel == `FLAG_V); // RULE3
        overflow_clear_op      = flag_clear_go && (flag_op.flag_sel == `FLAG_V); // RULE3
        sign_flag_set_op       = flag_set_go && (flag_op.flag_sel == `FLAG_S); // RULE2
        sign_flag_clear_op     = flag_clear_go && (flag_op.flag_sel == `FLAG_S); // RULE2
        half_carry_set_op      = flag_set_go && (flag_op.flag_sel == `FLAG_H); // RULE4
        half_carry_clear_op    = flag_clear_go && (flag_op.flag_sel == `FLAG_H); // RULE4
        transfer_flag_set_op   = flag_set_go && (flag_op.flag_sel == `FLAG_T); // RULE8
        transfer_flag_clear_op = flag_clear_go && (flag_op.flag_sel == `FLAG_T); // RULE8
        global_irq_enable_op   = flag_set_go && (flag_op.flag_sel == `FLAG_I); // RULE8
        global_irq_disable_op  = flag_clear_go && (flag_op.flag_sel == `FLAG_I); // RULE8
    end

    // strobes gathered by flag position, so the bit order lives in the map only
    always_comb begin
        flag_set_mask            = 8'h00;
        flag_clear_mask          = 8'h00;
        flag_set_mask[`FLAG_C]   = carry_set_op;
        flag_clear_mask[`FLAG_C] = carry_clear_op;
        flag_set_mask[`FLAG_Z]   = zero_flag_set_op;
        flag_clear_mask[`FLAG_Z] = zero_flag_clear_op;
        flag_set_mask[`FLAG_N]   = negative_set_op;
        flag_clear_mask[`FLAG_N] = negative_clear_op;
        flag_set_mask[`FLAG_V]   = overflow_set_op;
        flag_clear_mask[`FLAG_V] = overflow_clear_op;
        flag_set_mask[`FLAG_S]   = sign_flag_set_op;
        flag_clear_mask[`FLAG_S] = sign_flag_clear_op;
        flag_set_mask[`FLAG_H]   = half_carry_set_op;
        flag_clear_mask[`FLAG_H] = half_carry_clear_op;
        flag_set_mask[`FLAG_T]   = transfer_flag_set_op;
        flag_clear_mask[`FLAG_T] = transfer_flag_clear_op;
        flag_set_mask[`FLAG_I]   = global_irq_enable_op;
        flag_clear_mask[`FLAG_I] = global_irq_disable_op;
    end

    // one slice per bit: a flag moves only when its own strobe fires
    genvar g;
    generate
        for (g = 0; g < 8; g++) begin : g_bit
            always_comb begin
                nxt_status_flag_register[g] = status_flag_register_ff[g];
                if (flag_set_mask[g]) begin
                    nxt_status_flag_register[g] = 1'b1; // RULE2 RULE3 RULE4 RULE8
                end else if (flag_clear_mask[g]) begin
                    nxt_status_flag_register[g] = 1'b0; // RULE2 RULE3 RULE4 RULE8
                end
            end
            // destination bit takes the transfer flag only where the index points
            always_comb begin
                load_bits[g] = rd_value[g];
                if (bit_load.bit_sel == 3'(g)) begin
                    load_bits[g] = status_flag_register_ff[`FLAG_T]; // RULE1
                end
            end
        end
    endgenerate

    always_ff @(posedge clk or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            status_flag_register_ff <= `STATUS_FLAG_REGISTER_RESET;
        end else begin
            status_flag_register_ff <= nxt_status_flag_register;
        end
    end

    // write-back is registered: the register file sees the write a cycle later
    always_comb begin
        transfer_bit_load = bit_load.valid;
        nxt_wr_en         = transfer_bit_load; // RULE1
        nxt_wr_sel        = bit_load.reg_sel;
        nxt_wr_data       = load_bits; // RULE1
    end

    always_ff @(posedge clk or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            wr_en_ff   <= 1'b0;
            wr_sel_ff  <= 5'h00;
            wr_data_ff <= 8'h00;
        end else begin
            wr_en_ff   <= nxt_wr_en;
            wr_sel_ff  <= nxt_wr_sel;
            wr_data_ff <= nxt_wr_data;
        end
    end

    // system words only raise pulses; the flag register never sees them
    always_comb begin
        sleep_op            = (sys_op == flag_ops_pkg::SYS_SLEEP);
        watchdog_restart_op = (sys_op == flag_ops_pkg::SYS_WATCHDOG);
        break_op            = (sys_op == flag_ops_pkg::SYS_BREAK);
        // without debug hardware a break acts as no operation
        nxt_sleep           = sleep_op; // RULE5
        nxt_wdog            = watchdog_restart_op; // RULE6
        nxt_brk             = break_op && debug_enabled; // RULE7
    end

    always_ff @(posedge clk or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            sleep_ff <= 1'b0;
            wdog_ff  <= 1'b0;
            brk_ff   <= 1'b0;
        end else begin
            sleep_ff <= nxt_sleep;
            wdog_ff  <= nxt_wdog;
            brk_ff   <= nxt_brk;
        end
    end

    assign status_flags  = status_flag_register_ff;
    assign wr_en         = wr_en_ff;
    assign wr_sel        = wr_sel_ff;
    assign wr_data       = wr_data_ff;
    assign sleep_req     = sleep_ff;
    assign watchdog_kick = wdog_ff;
    assign debug_break   = brk_ff;
endmodule : status_flag_and_system_ops

/* File: dv/sfo_checker_assertions.sv */
// assertions on the ports of the flag and system-op block
// assumes every answer lands exactly one clock after the taking edge
module sfo_checker (
    input wire logic        clk, arst_n, insn_valid, debug_enabled, wr_en,
    input wire logic        sleep_req, watchdog_kick, debug_break,
    input wire logic [15:0] insn,
    input wire logic [7:0]  rd_value, status_flags, wr_data,
    input wire logic [4:0]  wr_sel
);
    logic       fop, bl, sl, wk, be;
    logic [7:0] m, nf, wd;
    assign fop = insn_valid && (insn & 16'hff0f) == 16'h9408;
    assign bl = insn_valid && (insn & 16'hfe08) == 16'hf800;
    assign sl = insn_valid && insn == 16'h9588;
    assign wk = insn_valid && insn == 16'h95a8;
    assign be = insn_valid && insn == 16'h9598 && debug_enabled;
    assign m = 8'h01 << insn[6:4];
    assign nf = insn[7] ? status_flags & ~m : status_flags | m;
    // bit b of the destination is replaced by the transfer flag as it stood
    assign wd = (rd_value & ~(8'h01 << insn[2:0])) | ({7'h00, status_flags[6]} << insn[2:0]);
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    flag_upd_a: assert property (fop |=> status_flags == $past(nf))
        else $error("flag op result wrong");
    flag_keep_a: assert property (!fop |=> $stable(status_flags))
        else $error("flags moved without flag op");
    bl_strobe_a: assert property (1 |=> wr_en == $past(bl))
        else $error("write strobe wrong");
    bl_sel_a: assert property (bl |=> wr_sel == $past(insn[8:4]))
        else $error("write index wrong");
    bl_data_a: assert property (bl |=> wr_data == $past(wd))
        else $error("write data wrong");
    sleep_pulse_a: assert property (1 |=> sleep_req == $past(sl))
        else $error("sleep pulse wrong");
    kick_pulse_a: assert property (1 |=> watchdog_kick == $past(wk))
        else $error("watchdog pulse wrong");
    break_pulse_a: assert property (1 |=> debug_break == $past(be))
        else $error("break pulse wrong");
endmodule : sfo_checker
bind status_flag_and_system_ops sfo_checker chk (.*);

/* File: dv/test_status_flag_and_system_ops.sv */
// self-checking bench for the flag and system-op block
// assumes a one-cycle answer and a two-flop reset release
module test_status_flag_and_system_ops;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk           = 1'h0;
    logic        arst_n        = 1'h0;
    logic        insn_valid    = 1'h0;
    logic        debug_enabled = 1'h0;
    logic        wr_en;
    logic        sleep_req;
    logic        watchdog_kick;
    logic        debug_break;
    logic [3:0]  strobes;
    logic [15:0] insn          = 16'h0000;
    logic [7:0]  rd_value      = 8'h00;
    logic [7:0]  status_flags;
    logic [7:0]  wr_data;
    logic [7:0]  sf            = 8'h00;
    logic [4:0]  wr_sel;
    int          miscompares   = 0;
    int          tests_run     = 0;
    int          cyc           = 0;

    status_flag_and_system_ops dut (
        .clk           (clk),
        .arst_n        (arst_n),
        .insn_valid    (insn_valid),
        .insn          (insn),
        .rd_value      (rd_value),
        .debug_enabled (debug_enabled),
        .status_flags  (status_flags),
        .wr_en         (wr_en),
        .wr_sel        (wr_sel),
        .wr_data       (wr_data),
        .sleep_req     (sleep_req),
        .watchdog_kick (watchdog_kick),
        .debug_break   (debug_break)
    );

    assign strobes = {wr_en, sleep_req, watchdog_kick, debug_break};

    always #10 clk = ~clk;

    // the scenarios need well under a hundred cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc > 1000) begin
            miscompares++;
            tally_and_finish();
        end
    end
    task automatic chk(string nm, logic [15:0] got, logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %s exp %h got %h", nm, exp, got);
        end
    endtask : chk
    // inputs stay up so words can follow back to back; idle drops insn_valid only
    task automatic issue(logic [15:0] w, logic [7:0] r);
        insn_valid = 1'h1;
        insn       = w;
        rd_value   = r;
        @(posedge clk);
        #2;
    endtask : issue
    task automatic idle();
        insn_valid = 1'h0;
        @(posedge clk);
        #2;
        chk("strobes", 16'(strobes), 16'h0000);
    endtask : idle
    task automatic t_flags();
        for (int i = 0; i < 16; i++) begin
            issue({8'h94, i[3], i[2:0], 4'h8}, 8'h00);
            sf[i[2:0]] = !i[3];
            chk("flags", 16'(status_flags), 16'(sf));
        end
        idle();
    endtask : t_flags
    task automatic bl(logic [4:0] d, logic [2:0] b, logic [7:0] r);
        logic [7:0] e;
        e = r;
        e[b] = sf[6];
        issue({7'h7c, d, 1'b0, b}, r);
        chk("wr_en", 16'(wr_en), 16'h0001);
        chk("wr_sel", 16'(wr_sel), 16'(d));
        chk("wr_data", 16'(wr_data), 16'(e));
        chk("flags", 16'(status_flags), 16'(sf));
    endtask : bl
    task automatic t_bitload();
        issue(16'h9468, 8'h00);
        sf[6] = 1'h1;
        bl(5'h1f, 3'h7, 8'h00);
        bl(5'h00, 3'h0, 8'hfe);
        issue(16'h94e8, 8'h00);
        sf[6] = 1'h0;
        bl(5'h11, 3'h3, 8'hff);
        idle();
    endtask : t_bitload
    task automatic sys(logic [15:0] w, logic d, logic [2:0] e);
        debug_enabled = d;
        issue(w, 8'h5a);
        chk("pulses", 16'(strobes), 16'({1'h0, e}));
        chk("flags", 16'(status_flags), 16'(sf));
    endtask : sys
    // a mid-run reset with every flag already clear keeps them clear; a flag word without valid is ignored
    task automatic t_reset();
        arst_n     = 1'h0;
        insn_valid = 1'h0;
        insn       = 16'h9408;
        @(posedge clk);
        #2;
        chk("reset strobes", 16'(strobes), 16'h0000);
        arst_n = 1'h1;
        repeat (3) @(posedge clk);
        #2;
        sf = 8'h00;
        chk("reset flags", 16'(status_flags), 16'(sf));
        issue(16'h9408, 8'h00);
        sf[0] = 1'h1;
        chk("flags", 16'(status_flags), 16'(sf));
    endtask : t_reset
    task automatic tally_and_finish();
        $display("miscompares %0d tests_run %0d", miscompares, tests_run);
        if (miscompares == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : tally_and_finish
    initial begin
        repeat (16) @(posedge clk);
        #2 arst_n = 1'h1;
        repeat (2) @(posedge clk);
        #2;
        chk("reset flags", 16'(status_flags), 16'h0000);
        chk("reset strobes", 16'(strobes), 16'h0000);
        t_flags();
        t_bitload();
        sys(16'h9588, 1'h0, 3'h4);
        sys(16'h95a8, 1'h0, 3'h2);
        sys(16'h9598, 1'h1, 3'h1);
        sys(16'h9598, 1'h0, 3'h0);
        sys(16'h9409, 1'h1, 3'h0);
        t_reset();
        idle();
        tally_and_finish();
    end
endmodule : test_status_flag_and_system_ops
